/* File: hw/sgss_defs.vh */
/*
 * constants of the servo gain set switcher: register byte offsets,
 * field positions, reset values and timing counts.
 * assumes inclusion by the switcher and its bench; definitions only.
 */
`ifndef SGSS_DEFS_VH
`define SGSS_DEFS_VH

// ************************************************************
// register byte offsets (one aligned 32-bit word each)
// ************************************************************
`define SGSS_OFS_CONFIG 8'h00
`define SGSS_OFS_WAIT_TO_SET2 8'h04
`define SGSS_OFS_WAIT_TO_SET1 8'h08
`define SGSS_OFS_RAMP_TO_SET2 8'h0C
`define SGSS_OFS_RAMP_TO_SET1 8'h10
`define SGSS_OFS_STATUS 8'h14
`define SGSS_OFS_GAIN_BASE 8'h40
`define SGSS_GAIN_COUNT 7
`define SGSS_GAIN_ENTRIES 14

// ************************************************************
// config field positions and encodings
// ************************************************************
`define SGSS_CFG_MODE_LSB 0
`define SGSS_CFG_COND_LSB 4
`define SGSS_CFG_LOOP_LSB 8
`define SGSS_MODE_MANUAL 4'h0
`define SGSS_MODE_AUTO 4'h2
`define SGSS_LOOP_PI 4'h0
`define SGSS_LOOP_IP 4'h1
`define SGSS_CONFIG_RESET 12'h000

// ************************************************************
// gain entry indices inside one set
// ************************************************************
`define SGSS_IDX_SPEED_GAIN 0
`define SGSS_IDX_SPEED_INTEG 1
`define SGSS_IDX_POS_GAIN 2
`define SGSS_IDX_TORQUE_FILT 3
`define SGSS_IDX_MF_GAIN 4
`define SGSS_IDX_MF_COMP 5
`define SGSS_IDX_FRICTION 6

// ************************************************************
// gain reset values, same in both sets
// ************************************************************
`define SGSS_RST_SPEED_GAIN 16'h0190
`define SGSS_RST_SPEED_INTEG 16'h07D0
`define SGSS_RST_POS_GAIN 16'h0190
`define SGSS_RST_TORQUE_FILT 16'h0064
`define SGSS_RST_MF_GAIN 16'h01F4
`define SGSS_RST_MF_COMP 16'h03E8
`define SGSS_RST_FRICTION 16'h0064
`define SGSS_RST_TIME 16'h0000

// ************************************************************
// timing: 1 ms unit at a 25 ns clock
// ************************************************************
`define SGSS_TIME_UNIT_NS 1000000
`define SGSS_CLK_PERIOD_NS 25
`define SGSS_CYC_PER_MS (`SGSS_TIME_UNIT_NS / `SGSS_CLK_PERIOD_NS)

`endif

/* File: hw/sgss_switcher.v */
/*
 * servo gain set switcher: two gain sets, manual or automatic
 * selection, wait then linear ramp, Avalon-MM register slave.
 * assumes clk_sys at 40 MHz, synchronous active-high reset, and
 * status pins arriving asynchronously from the drive.
 */
`timescale 1ns/100ps
`include "sgss_defs.vh"

// Behaviour
// - mode field: 0 manual (reset default), 2 automatic.
// - two whole gain sets of seven values; switching selects a set's five non-model-following values.
// - model-following values switch between sets only in manual mode.
// - model-following values change only when no command runs and motor stopped.
// - in manual mode the gain-select command picks set 1 or set 2.
// - automatic: condition true moves set 1 to 2 with first wait and ramp.
// - automatic: condition false moves set 2 to 1 with second wait and ramp.
// - position control decodes selector 0..5 into six condition sources.
// - outside position control selector 0,2,4 fixes set 1; 1,3,5 set 2.
// - transition start is delayed by the programmed waiting time.
// - after the wait, position gain moves linearly over the switching time.
// - automatic switching only with PI or I-P loop structure.
// - wait and switching times 0..65535 in 1 ms units, default 0.
// - monitor reports 1 for set 1 and 2 for set 2.
module sgss_switcher #(
    parameter CYC_PER_MS = `SGSS_CYC_PER_MS
) (
    input wire clk_sys,
    input wire reset,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire positioning_done_flag,
    input wire near_flag,
    input wire ref_pulse_active,
    input wire pos_filter_empty,
    input wire position_control,
    input wire gain_select_command,
    input wire command_busy,
    input wire motor_stopped,
    output wire [15:0] speed_gain,
    output wire [15:0] speed_integ_time,
    output wire [15:0] position_gain,
    output wire [15:0] torque_filter_time,
    output wire [15:0] model_follow_gain,
    output wire [15:0] model_follow_comp,
    output wire [15:0] friction_comp_gain,
    output reg [1:0] active_gain_monitor,
    output reg switch_busy
);

    // ************************************************************
    // states
    // ************************************************************
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_WAIT = 2'b01;
    localparam [1:0] ST_RAMP = 2'b10;
    localparam [31:0] MS_LAST = CYC_PER_MS - 1;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    wire [7:0] pin_raw;
    reg [7:0] pin_meta_q;
    reg [7:0] pin_sync_q;

    assign pin_raw = {motor_stopped, command_busy, gain_select_command, position_control,
                      pos_filter_empty, ref_pulse_active, near_flag, positioning_done_flag};
    // two flops per pin, second one alone is read
    always @(posedge clk_sys) begin
        if (reset) begin
            pin_meta_q <= 8'h00;
            pin_sync_q <= 8'h00;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
        end
    end

    wire positioning_done_flag_s = pin_sync_q[0];
    wire near_s = pin_sync_q[1];
    wire pulse_s = pin_sync_q[2];
    wire filt_empty_s = pin_sync_q[3];
    wire pos_ctrl_s = pin_sync_q[4];
    wire gsel_s = pin_sync_q[5];
    wire cmd_busy_s = pin_sync_q[6];
    wire stopped_s = pin_sync_q[7];

    // ************************************************************
    // registers
    // ************************************************************
    reg [11:0] config_q;
    reg [15:0] wait2_q;
    reg [15:0] wait1_q;
    reg [15:0] ramp2_q;
    reg [15:0] ramp1_q;
    reg [15:0] gain_q [0:`SGSS_GAIN_ENTRIES-1];
    reg [15:0] eff_q [0:`SGSS_GAIN_COUNT-1];
    reg [15:0] from_q [0:`SGSS_GAIN_COUNT-1];
    reg [1:0] state_q;
    reg act_set_q;
    reg dir_q;
    reg mf_set_q;
    reg [15:0] ms_cnt_q;
    reg [31:0] tick_cnt_q;
    reg ms_tick_q;

    wire [3:0] mode = config_q[`SGSS_CFG_MODE_LSB +: 4];
    wire [3:0] cond_sel = config_q[`SGSS_CFG_COND_LSB +: 4];
    wire [3:0] loop_sel = config_q[`SGSS_CFG_LOOP_LSB +: 4];
    // write accepted while waitrequest is low
    wire wr_acc = avs_write & ~avs_waitrequest;
    wire gain_hit = (avs_address >= `SGSS_OFS_GAIN_BASE) &&
                    (avs_address < `SGSS_OFS_GAIN_BASE + 8'd56) && (avs_address[1:0] == 2'b00);
    wire [7:0] gain_off = avs_address - `SGSS_OFS_GAIN_BASE;
    wire [3:0] gain_idx = gain_off[5:2];

    // ************************************************************
    // avalon slave: one wait cycle then answer
    // ************************************************************
    always @(posedge clk_sys) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if ((avs_read | avs_write) & avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            if (avs_read) begin
                if (gain_hit) begin
                    avs_readdata <= {16'h0000, gain_q[gain_idx]};
                end else begin
                    case (avs_address)
                        `SGSS_OFS_CONFIG: avs_readdata <= {20'h0_0000, config_q};
                        `SGSS_OFS_WAIT_TO_SET2: avs_readdata <= {16'h0000, wait2_q};
                        `SGSS_OFS_WAIT_TO_SET1: avs_readdata <= {16'h0000, wait1_q};
                        `SGSS_OFS_RAMP_TO_SET2: avs_readdata <= {16'h0000, ramp2_q};
                        `SGSS_OFS_RAMP_TO_SET1: avs_readdata <= {16'h0000, ramp1_q};
                        `SGSS_OFS_STATUS: avs_readdata <= {26'h000_0000, state_q, mf_set_q,
                                                           switch_busy, active_gain_monitor};
                        default: avs_readdata <= 32'h0000_0000;
                    endcase
                end
            end
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // config and time registers, live at once
    always @(posedge clk_sys) begin
        if (reset) begin
            config_q <= `SGSS_CONFIG_RESET;
            wait2_q <= `SGSS_RST_TIME;
            wait1_q <= `SGSS_RST_TIME;
            ramp2_q <= `SGSS_RST_TIME;
            ramp1_q <= `SGSS_RST_TIME;
        end else if (wr_acc) begin
            case (avs_address)
                `SGSS_OFS_CONFIG: config_q <= avs_writedata[11:0];
                `SGSS_OFS_WAIT_TO_SET2: wait2_q <= avs_writedata[15:0];
                `SGSS_OFS_WAIT_TO_SET1: wait1_q <= avs_writedata[15:0];
                `SGSS_OFS_RAMP_TO_SET2: ramp2_q <= avs_writedata[15:0];
                `SGSS_OFS_RAMP_TO_SET1: ramp1_q <= avs_writedata[15:0];
                default: ;
            endcase
        end
    end

    // fourteen gain entries, set 1 at 0..6, set 2 at 7..13
    genvar gi;
    generate
        for (gi = 0; gi < `SGSS_GAIN_ENTRIES; gi = gi + 1) begin : g_entry
            localparam integer K = gi % `SGSS_GAIN_COUNT;
            localparam [15:0] RST = (K == `SGSS_IDX_SPEED_GAIN) ? `SGSS_RST_SPEED_GAIN :
                                    (K == `SGSS_IDX_SPEED_INTEG) ? `SGSS_RST_SPEED_INTEG :
                                    (K == `SGSS_IDX_POS_GAIN) ? `SGSS_RST_POS_GAIN :
                                    (K == `SGSS_IDX_TORQUE_FILT) ? `SGSS_RST_TORQUE_FILT :
                                    (K == `SGSS_IDX_MF_GAIN) ? `SGSS_RST_MF_GAIN :
                                    (K == `SGSS_IDX_MF_COMP) ? `SGSS_RST_MF_COMP :
                                    `SGSS_RST_FRICTION;
            always @(posedge clk_sys) begin
                if (reset) begin
                    gain_q[gi] <= RST;
                end else if (wr_acc && gain_hit && (gain_idx == gi)) begin
                    gain_q[gi] <= avs_writedata[15:0];
                end
            end
        end
    endgenerate

    // ************************************************************
    // target set decode
    // ************************************************************
    reg cond_a;
    // condition a sources under position control
    always @* begin
        case (cond_sel)
            4'h0: cond_a = positioning_done_flag_s;
            4'h1: cond_a = ~positioning_done_flag_s;
            4'h2: cond_a = near_s;
            4'h3: cond_a = ~near_s;
            4'h4: cond_a = filt_empty_s & ~pulse_s;
            4'h5: cond_a = pulse_s;
            default: cond_a = 1'b0;
        endcase
    end

    // outside position control the selector fixes the set
    wire fixed_set = (cond_sel <= 4'h5) ? cond_sel[0] : 1'b0;
    wire auto_tgt = pos_ctrl_s ? cond_a : fixed_set;
    // automatic only with pi or i-p loop structure
    wire loop_ok = (loop_sel == `SGSS_LOOP_PI) || (loop_sel == `SGSS_LOOP_IP);
    wire auto_mode = (mode == `SGSS_MODE_AUTO);
    wire auto_en = auto_mode && loop_ok;
    wire [15:0] wait_lim = dir_q ? wait2_q : wait1_q;
    wire [15:0] ramp_lim = dir_q ? ramp2_q : ramp1_q;

    // ************************************************************
    // millisecond enable, restarted on each state entry
    // ************************************************************
    wire tick_clr;
    always @(posedge clk_sys) begin
        if (reset || tick_clr) begin
            tick_cnt_q <= 32'h0000_0000;
            ms_tick_q <= 1'b0;
        end else if (tick_cnt_q == MS_LAST) begin
            tick_cnt_q <= 32'h0000_0000;
            ms_tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            ms_tick_q <= 1'b0;
        end
    end

    // ************************************************************
    // switching state machine
    // ************************************************************
    reg [1:0] state_d;
    reg act_set_d;
    reg dir_d;
    reg [15:0] ms_cnt_d;
    reg snap;
    assign tick_clr = (state_d != state_q);
    always @* begin
        state_d = state_q;
        act_set_d = act_set_q;
        dir_d = dir_q;
        ms_cnt_d = ms_cnt_q;
        snap = 1'b0;
        if (!auto_mode) begin
            // manual: select command picks the set at once
            state_d = ST_IDLE;
            act_set_d = gsel_s;
        end else if (!auto_en) begin
            state_d = ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (auto_tgt != act_set_q) begin
                        state_d = ST_WAIT;
                        dir_d = auto_tgt;
                        ms_cnt_d = 16'h0000;
                    end
                end
                ST_WAIT: begin
                    // hold off the ramp for the waiting time
                    if (auto_tgt != dir_q) begin
                        state_d = ST_IDLE;
                    end else if (ms_cnt_q >= wait_lim) begin
                        act_set_d = dir_q;
                        ms_cnt_d = 16'h0000;
                        snap = 1'b1;
                        state_d = (ramp_lim == 16'h0000) ? ST_IDLE : ST_RAMP;
                    end else if (ms_tick_q) begin
                        ms_cnt_d = ms_cnt_q + 16'h0001;
                    end
                end
                ST_RAMP: begin
                    if (ms_cnt_q >= ramp_lim) begin
                        state_d = ST_IDLE;
                    end else if (ms_tick_q) begin
                        ms_cnt_d = ms_cnt_q + 16'h0001;
                    end
                end
                default: state_d = ST_IDLE;
            endcase
        end
    end

    // state registers and monitor
    always @(posedge clk_sys) begin
        if (reset) begin
            state_q <= ST_IDLE;
            act_set_q <= 1'b0;
            dir_q <= 1'b0;
            ms_cnt_q <= 16'h0000;
            active_gain_monitor <= 2'b01;
            switch_busy <= 1'b0;
        end else begin
            state_q <= state_d;
            act_set_q <= act_set_d;
            dir_q <= dir_d;
            ms_cnt_q <= ms_cnt_d;
            active_gain_monitor <= act_set_d ? 2'b10 : 2'b01;
            switch_busy <= (state_d != ST_IDLE);
        end
    end

    // model-following set moves only in manual, idle and stopped
    always @(posedge clk_sys) begin
        if (reset) begin
            mf_set_q <= 1'b0;
        end else if (!auto_mode && !cmd_busy_s && stopped_s) begin
            mf_set_q <= gsel_s;
        end
    end

    // ************************************************************
    // effective gain outputs
    // ************************************************************
    genvar ei;
    generate
        for (ei = 0; ei < `SGSS_GAIN_COUNT; ei = ei + 1) begin : g_eff
            localparam IS_MF = (ei == `SGSS_IDX_MF_GAIN) || (ei == `SGSS_IDX_MF_COMP);
            wire [15:0] to_val = act_set_q ? gain_q[ei + `SGSS_GAIN_COUNT] : gain_q[ei];
            wire [15:0] mf_val = mf_set_q ? gain_q[ei + `SGSS_GAIN_COUNT] : gain_q[ei];
            wire up = (to_val >= from_q[ei]);
            wire [15:0] diff = up ? (to_val - from_q[ei]) : (from_q[ei] - to_val);
            wire [31:0] prod = diff * ms_cnt_q;
            wire [31:0] lim32 = {16'h0000, (ramp_lim == 16'h0000) ? 16'h0001 : ramp_lim};
            wire [31:0] step = prod / lim32;
            wire [15:0] ramp_val = up ? (from_q[ei] + step[15:0]) : (from_q[ei] - step[15:0]);
            always @(posedge clk_sys) begin
                if (reset) begin
                    eff_q[ei] <= gain_q[ei];
                    from_q[ei] <= 16'h0000;
                end else begin
                    if (snap) begin
                        from_q[ei] <= eff_q[ei];
                    end
                    if (IS_MF) begin
                        eff_q[ei] <= mf_val;
                    end else if (state_q == ST_RAMP) begin
                        // linear move from old to new value
                        eff_q[ei] <= ramp_val;
                    end else if (!snap) begin
                        eff_q[ei] <= to_val;
                    end
                end
            end
        end
    endgenerate
    assign speed_gain = eff_q[`SGSS_IDX_SPEED_GAIN];
    assign speed_integ_time = eff_q[`SGSS_IDX_SPEED_INTEG];
    assign position_gain = eff_q[`SGSS_IDX_POS_GAIN];
    assign torque_filter_time = eff_q[`SGSS_IDX_TORQUE_FILT];
    assign model_follow_gain = eff_q[`SGSS_IDX_MF_GAIN];
    assign model_follow_comp = eff_q[`SGSS_IDX_MF_COMP];
    assign friction_comp_gain = eff_q[`SGSS_IDX_FRICTION];
endmodule // sgss_switcher

/* File: sim/sgss_option_model.sv */
/* option module and drive status model: drives the select and status pins.
   assumes pin_req from the bench; lag delays requests. */
`timescale 1ns/100ps
module sgss_option_model (
    input wire clk_sys,
    input wire [7:0] pin_req,
    input wire [1:0] lag,
    output logic [7:0] pins
);
    logic [7:0] pipe_q [0:3];
    initial begin
        pipe_q = '{default: 8'h04};
        pins = 8'h04;
    end
    always @(posedge clk_sys) begin
        pipe_q[0] <= pin_req;
        pipe_q[1] <= pipe_q[0];
        pipe_q[2] <= pipe_q[1];
        pipe_q[3] <= pipe_q[2];
        pins <= (lag == 2'd0) ? pin_req : pipe_q[lag - 2'd1];
    end
endmodule // sgss_option_model

/* File: sim/sgss_switcher_sva.sv */
/* checker for sgss_switcher: bus timing, set selection, model-following hold.
   assumes binding to sgss_switcher and sight of its ports only. */
`timescale 1ns/100ps
module sgss_switcher_sva (
    input wire clk_sys,
    input wire reset,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire gain_select_command,
    input wire command_busy,
    input wire motor_stopped,
    input wire [15:0] model_follow_gain,
    input wire [15:0] model_follow_comp,
    input wire [1:0] active_gain_monitor,
    input wire switch_busy
);
    reg [11:0] cfg_q;
    wire mode_auto = cfg_q[3:0] == 4'h2;
    wire loop_ok = cfg_q[11:8] <= 4'h1;
    // config word copied from accepted writes
    always @(posedge clk_sys) begin
        if (reset)
            cfg_q <= 12'h000;
        else if (avs_write && !avs_waitrequest && avs_address == 8'h00)
            cfg_q <= avs_writedata[11:0];
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ************************************************************
    // assertions
    // ************************************************************
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer after one wait");
    AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    AST_UNMAPPED_ZERO: assert property (avs_read && !avs_waitrequest && avs_address >= 8'h78 |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_NO_BUSY_IDLE: assert property ((!mode_auto || !loop_ok) [*3] |-> !switch_busy)
        else $error("busy outside automatic mode");
    AST_MF_FROZEN_AUTO: assert property (mode_auto [*3] |-> $stable(model_follow_gain) && $stable(model_follow_comp))
        else $error("model-following moved in auto");
    AST_MF_HOLD_BUSY: assert property ((command_busy || !motor_stopped) [*5] |-> $stable(model_follow_gain) && $stable(model_follow_comp))
        else $error("model-following moved while busy");
    AST_SYNC_GAP: assert property (!mode_auto && $changed(gain_select_command) |=> $stable(active_gain_monitor))
        else $error("monitor skipped synchroniser");
    AST_MANUAL_SEL: assert property ((!mode_auto && $stable(gain_select_command)) [*6] |-> active_gain_monitor == (gain_select_command ? 2'd2 : 2'd1))
        else $error("monitor not following select");
    AST_MON_LEGAL: assert property (active_gain_monitor == 2'd1 || active_gain_monitor == 2'd2)
        else $error("monitor value not 1 or 2");
    COV_BUSY: cover property ($rose(switch_busy));
    COV_AUTO_SET2: cover property (mode_auto && active_gain_monitor == 2'd2);
    COV_UNMAPPED: cover property (avs_read && !avs_waitrequest && avs_address >= 8'h78);
endmodule // sgss_switcher_sva

bind sgss_switcher sgss_switcher_sva i_sgss_switcher_sva (.clk_sys(clk_sys), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .gain_select_command(gain_select_command),
    .command_busy(command_busy), .motor_stopped(motor_stopped), .model_follow_gain(model_follow_gain),
    .model_follow_comp(model_follow_comp), .active_gain_monitor(active_gain_monitor), .switch_busy(switch_busy));

/* File: sim/sgss_switcher_test.sv */
/* self-checking bench of sgss_switcher with a reference model.
   assumes hw/ on the include path and a 10-cycle millisecond. */
`timescale 1ns/100ps
`include "sgss_defs.vh"
module sgss_switcher_test;
    reg clk_sys;
    reg reset = 1'b1;
    reg [7:0] avs_address = 8'h00;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0000_0000;
    reg [7:0] pin_req = 8'h04;
    reg [1:0] lag = 2'd0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire [15:0] g_out [0:6];
    wire [1:0] active_gain_monitor;
    wire switch_busy;
    wire [7:0] pins;
    int fails = 0;
    int n_compared = 0;
    int seed = 32'h4cc8_a738;
    int g [0:13];
    int rst [0:6] = '{16'h0190, 16'h07D0, 16'h0190, 16'h0064, 16'h01F4, 16'h03E8, 16'h0064};
    int cur, c, sel, lp, cp, fp, cs, fs;
    logic [31:0] q;
    logic [11:0] cfg;
    logic [7:0] pr;
    sgss_option_model i_sgss_option_model (.clk_sys(clk_sys), .pin_req(pin_req), .lag(lag), .pins(pins));
    sgss_switcher #(.CYC_PER_MS(10)) i_sgss_switcher (.clk_sys(clk_sys), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .positioning_done_flag(pins[3]),
        .near_flag(pins[4]), .ref_pulse_active(pins[5]), .pos_filter_empty(pins[6]), .position_control(pins[7]),
        .gain_select_command(pins[0]), .command_busy(pins[1]), .motor_stopped(pins[2]),
        .speed_gain(g_out[0]), .speed_integ_time(g_out[1]), .position_gain(g_out[2]),
        .torque_filter_time(g_out[3]), .model_follow_gain(g_out[4]), .model_follow_comp(g_out[5]),
        .friction_comp_gain(g_out[6]), .active_gain_monitor(active_gain_monitor), .switch_busy(switch_busy));
    // clock at 25 ns
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic finish_test();
        if (fails == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one Avalon access, held until waitrequest is sampled low
    task automatic bus(input bit wr, input [7:0] a, input [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            fails++;
            finish_test();
        end
    endtask
    task automatic rd(input [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk("register read", exp, q);
    endtask
    task automatic chk_set(input int s, input int mfs);
        for (int i = 0; i < 7; i++)
            chk("gain output", g[((i == 4 || i == 5) ? mfs : s) * 7 + i], {16'h0000, g_out[i]});
        chk("gain monitor", s + 1, {30'h0, active_gain_monitor});
    endtask
    // counts changes of one gain output
    task automatic watch(input int ncyc, input int idx, output int chg, output int first);
        logic [15:0] prev;
        prev = g_out[idx];
        chg = 0;
        first = -1;
        for (int k = 0; k < ncyc; k++) begin
            @(posedge clk_sys);
            if (g_out[idx] !== prev && first < 0)
                first = k;
            chg += (g_out[idx] !== prev);
            prev = g_out[idx];
        end
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        for (int i = 0; i < 14; i++)
            g[i] = rst[i % 7];
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        lag <= 2'($random(seed));
        for (int a = 0; a < 5; a++)
            rd(a * 4, 32'h0000_0000);
        bus(1'b0, `SGSS_OFS_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0001, q & 32'h0000_0007);
        for (int i = 0; i < 14; i++)
            rd(`SGSS_OFS_GAIN_BASE + i * 4, g[i]);
        bus(1'b1, 8'h80, 32'hFFFF_FFFF);
        rd(8'h80, 32'h0000_0000);
        bus(1'b1, `SGSS_OFS_WAIT_TO_SET2, 32'hFFFF_FFFF);
        rd(`SGSS_OFS_WAIT_TO_SET2, 32'h0000_FFFF);
        for (int i = 7; i < 14; i++) begin
            g[i] = rst[i - 7] + 16'h0100 + ($random(seed) & 32'h0000_0FFF);
            bus(1'b1, `SGSS_OFS_GAIN_BASE + i * 4, g[i]);
            rd(`SGSS_OFS_GAIN_BASE + i * 4, g[i]);
        end
        bus(1'b1, `SGSS_OFS_WAIT_TO_SET2, 32'h0000_0002);
        bus(1'b1, `SGSS_OFS_WAIT_TO_SET1, 32'h0000_0001);
        bus(1'b1, `SGSS_OFS_RAMP_TO_SET2, 32'h0000_0003);
        bus(1'b1, `SGSS_OFS_RAMP_TO_SET1, 32'h0000_0000);
        chk_set(0, 0);
        // manual select, then under a running command
        pin_req <= 8'h05;
        repeat (12) @(posedge clk_sys);
        chk_set(1, 1);
        pin_req <= 8'h06;
        repeat (12) @(posedge clk_sys);
        chk_set(0, 1);
        pin_req <= 8'h04;
        repeat (12) @(posedge clk_sys);
        chk_set(0, 0);
        // automatic, positioning done true: wait 2 ms then 3 ms ramp
        bus(1'b1, `SGSS_OFS_CONFIG, 32'h0000_0002);
        pin_req <= 8'h84;
        repeat (12) @(posedge clk_sys);
        chk_set(0, 0);
        pin_req <= 8'h8C;
        fork
            watch(90, 2, cp, fp);
            watch(90, 0, cs, fs);
            begin
                repeat (15) @(posedge clk_sys);
                chk("busy in wait", 1, {31'h0, switch_busy});
                chk("monitor in wait", 1, {30'h0, active_gain_monitor});
            end
        join
        chk("ramp steps", 3, cp);
        chk("ramp steps speed", 3, cs);
        chk("ramp start", 1, fp >= 30 && fp <= 45);
        chk_set(1, 0);
        chk("busy after ramp", 0, {31'h0, switch_busy});
        pin_req <= 8'h84;
        watch(40, 2, cp, fp);
        chk("jump steps", 1, cp);
        chk("jump start", 1, fp >= 10);
        chk_set(0, 0);
        for (int a = 1; a < 5; a++)
            bus(1'b1, a * 4, 32'h0000_0000);
        // selector cycled 0..5, random pins and loop structure
        cur = 0;
        for (int it = 0; it < 30; it++) begin
            sel = it % 6;
            lp = {$random(seed)} % 3;
            pr = 8'($random(seed)) & 8'hF8;
            cfg = {lp[3:0], sel[3:0], 4'h2};
            bus(1'b1, `SGSS_OFS_CONFIG, cfg);
            pin_req <= pr | 8'h04;
            case (sel)
                0: c = pr[3];
                1: c = !pr[3];
                2: c = pr[4];
                3: c = !pr[4];
                4: c = pr[6] && !pr[5];
                default: c = pr[5];
            endcase
            if (lp <= 1)
                cur = pr[7] ? c : sel % 2;
            repeat (20) @(posedge clk_sys);
            chk("auto monitor", cur + 1, {30'h0, active_gain_monitor});
            rd(`SGSS_OFS_CONFIG, cfg);
        end
        finish_test();
    end
endmodule // sgss_switcher_test
